// ---- bench/etl_monitor.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "etl_cfg.svh"
module etl_monitor
  import etl_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Bus.
  input wire logic [7:0] av_address,
  input wire logic av_read,
  input wire logic av_write,
  input wire logic [31:0] av_writedata,
  input wire logic [3:0] av_byteenable,
  input wire logic av_waitrequest,
  // Pins and streams.
  input wire logic [5:0] trig_pin,
  input wire logic rec_valid,
  input wire etl_rec_t rec_data,
  input wire logic rec_ready,
  input wire logic file_busy,
  input wire logic file_restart,
  input wire logic wake_req
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  chk_wait_one: assert property ((av_read || av_write) && av_waitrequest |=> !av_waitrequest)
    else $error("bus answer late");
  chk_wait_pulse: assert property (!av_waitrequest |=> av_waitrequest)
    else $error("wait low too long");
  chk_rec_hold: assert property (rec_valid && !rec_ready |=> rec_valid && $stable(rec_data))
    else $error("record dropped before taken");
  chk_rec_kind: assert property (rec_valid |-> rec_data.trig_num inside {[1:6]} &&
    rec_data.store inside {[ETL_STORE_TEXT:ETL_STORE_USB]}) else $error("bad record kind");
  chk_fmt_serial: assert property (rec_valid && rec_data.store >= ETL_STORE_SERIAL_ONE |->
    rec_data.fmt == ETL_FMT_CSV) else $error("serial not csv");
  chk_fmt_file: assert property (rec_valid |-> ((rec_data.store == ETL_STORE_TEXT) ==
    (rec_data.fmt == ETL_FMT_TEXT)) && ((rec_data.store == ETL_STORE_EPOCH) == (rec_data.fmt == ETL_FMT_EPOCH)))
    else $error("format mismatch");
  chk_busy_hold: assert property ($rose(rec_valid) && $past(file_busy) |->
    !(rec_data.store inside {[ETL_STORE_TEXT:ETL_STORE_EPOCH]})) else $error("file record while busy");
  chk_wake_cause: assert property (wake_req |-> $past(trig_pin) != $past(trig_pin, 2))
    else $error("wake without pin change");
  chk_restart_go: assert property (av_write && !av_waitrequest && av_address == `ETL_OFS_CTRL &&
    av_byteenable[0] && av_writedata[0] |=> file_restart ##1 !file_restart) else $error("restart pulse");
endmodule
bind etl_top etl_monitor u_mon (.clock, .nrst, .av_address, .av_read, .av_write, .av_writedata, .av_byteenable,
  .av_waitrequest, .trig_pin, .rec_valid, .rec_data, .rec_ready, .file_busy, .file_restart, .wake_req);
`default_nettype wire

// ---- bench/etl_switch_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module etl_switch_model (
  // Wanted levels and chatter request.
  input wire logic clock,
  input wire logic [5:0] level,
  input wire logic bounce,
  // Pins.
  output logic [5:0] trig_pin
);
  logic flip = 1'b0;
  // Real contacts chatter, so while bounce is high every pin is inverted on alternate cycles and changes every cycle.
  always @(posedge clock) flip <= !flip;
  assign trig_pin = level ^ ((bounce && flip) ? 6'h3F : 6'h00);
endmodule
`default_nettype wire

// ---- bench/test_edge_trigger_event_logger.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "etl_cfg.svh"
module test_edge_trigger_event_logger
  import etl_pkg::*;
;
  logic clock = 1'b0, nrst = 1'b0, av_read = 1'b0, av_write = 1'b0, bounce = 1'b0;
  logic rec_ready = 1'b1, file_busy = 1'b0;
  logic [7:0] av_address = 8'h00;
  logic [31:0] av_writedata = 32'h0, av_readdata, q;
  logic [3:0] av_byteenable = 4'hF;
  logic [5:0] level = 6'h3F, trig_pin;
  logic av_waitrequest, rec_valid, file_restart, wake_req, irq;
  etl_rec_t rec_data, r;
  int error_cnt = 0, n_compared = 0, cyc = 0, recs = 0, wakes = 0, rsts = 0;
  etl_top #(.MS_CYCLES(10)) u_dut (.clock, .nrst, .av_address, .av_read, .av_write, .av_writedata,
    .av_byteenable, .av_readdata, .av_waitrequest, .trig_pin, .rec_valid, .rec_data, .rec_ready,
    .file_busy, .file_restart, .wake_req, .irq);
  etl_switch_model u_sw (.clock, .level, .bounce, .trig_pin);
  initial begin
    forever #50 clock = ~clock;
  end
  task automatic stop_test;
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    if (rec_valid === 1'b1 && rec_ready) recs++;
    if (wake_req === 1'b1) wakes++;
    if (file_restart === 1'b1) rsts++;
    if (cyc++ == 5000) begin
      error_cnt++;
      stop_test;
    end
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    av_address <= a;
    av_writedata <= d;
    av_write <= wr;
    av_read <= !wr;
    // The wait ends when av_waitrequest reads low; only the bench timeout bounds it.
    do begin
      @(posedge clock);
    end while (av_waitrequest !== 1'b0);
    q = av_readdata;
    av_write <= 1'b0;
    av_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0);
    cmp(nm, e, q);
  endtask
  task automatic take;
    r = '0;
    repeat (100) begin
      @(posedge clock);
      if (rec_valid === 1'b1 && rec_ready) begin
        r = rec_data;
        return;
      end
    end
  endtask
  function automatic logic [31:0] hd(input etl_rec_t x);
    return {22'h0, x.trig_num, x.prev_lvl, x.new_lvl, x.store, x.fmt};
  endfunction
  task automatic t_text;
    bus(1'b1, `ETL_OFS_IRQ_MASK, 32'h1);
    bus(1'b1, `ETL_OFS_EPOCH_SEC, 32'h6066_4A81);
    bus(1'b1, `ETL_OFS_CFG_BASE, 32'h0064_0011);
    level[0] <= 1'b0;
    bounce <= 1'b1;
    take;
    cmp("text", {22'h0, 3'h1, 2'b10, ETL_STORE_TEXT, ETL_FMT_TEXT}, hd(r));
    cmp("sec", 32'h6066_4A81, r.epoch_sec);
    repeat (8) @(posedge clock);
    bounce <= 1'b0;
    level[0] <= 1'b1;
    repeat (4) @(posedge clock);
    cmp("recs", 1, recs);
    cmp("wake", 1, wakes);
    cmp("irq", 1, irq);
    rd(`ETL_OFS_FLAGS, 32'h1, "flag");
    rd(`ETL_OFS_FLAGS, 32'h0, "flag2");
    rd(`ETL_OFS_IRQ_STATUS, 32'h1, "sts");
    rd(`ETL_OFS_IRQ_STATUS, 32'h0, "sts2");
    cmp("irq0", 0, irq);
  endtask
  task automatic t_dbc;
    bus(1'b1, `ETL_OFS_CFG_BASE + 8'h04, 32'h0002_003D);
    level[1] <= 1'b0;
    take;
    cmp("epo", {22'h0, 3'h2, 2'b10, ETL_STORE_EPOCH, ETL_FMT_EPOCH}, hd(r));
    repeat (4) @(posedge clock);
    level[1] <= 1'b1;
    repeat (30) @(posedge clock);
    level[1] <= 1'b0;
    take;
    cmp("epo2", {22'h0, 3'h2, 2'b10, ETL_STORE_EPOCH, ETL_FMT_EPOCH}, hd(r));
    repeat (3) @(posedge clock);
    cmp("recs2", 3, recs);
    cmp("wake_suppress", 1, wakes);
    cmp("masked", 0, irq);
    rd(`ETL_OFS_IRQ_STATUS, 32'h2, "sts3");
  endtask
  task automatic t_busy;
    // Trigger one is still inside its 100 ms hold-off from the text scenario, so let it run out first.
    repeat (1010) @(posedge clock);
    file_busy <= 1'b1;
    rec_ready <= 1'b0;
    bus(1'b1, `ETL_OFS_CFG_BASE, 32'h0000_0021);
    bus(1'b1, `ETL_OFS_CFG_BASE + 8'h08, 32'h0000_0041);
    level[0] <= 1'b0;
    level[2] <= 1'b0;
    repeat (10) @(posedge clock);
    rec_ready <= 1'b1;
    take;
    cmp("ser", {22'h0, 3'h3, 2'b10, ETL_STORE_SERIAL_ONE, ETL_FMT_CSV}, hd(r));
    repeat (10) @(posedge clock);
    cmp("recs3", 4, recs);
    file_busy <= 1'b0;
    take;
    cmp("csv", {22'h0, 3'h1, 2'b10, ETL_STORE_CSV, ETL_FMT_CSV}, hd(r));
  endtask
  initial begin
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(`ETL_OFS_CFG_BASE, 32'h0064_0000, "cfg");
    rd(`ETL_OFS_IRQ_MASK, 32'h0, "mask");
    rd(8'hFC, 32'h0, "unmapped");
    t_text;
    t_dbc;
    t_busy;
    bus(1'b1, `ETL_OFS_CTRL, 32'h1);
    repeat (3) @(posedge clock);
    cmp("restart", 1, rsts);
    stop_test;
  end
endmodule
`default_nettype wire

// ---- verilog/etl_cfg.svh ----
`ifndef ETL_CFG_SVH
`define ETL_CFG_SVH

// Register byte offsets on the Avalon-MM slave.
`define ETL_OFS_CTRL 8'h00
`define ETL_OFS_IRQ_STATUS 8'h04
`define ETL_OFS_IRQ_MASK 8'h08
`define ETL_OFS_FLAGS 8'h0C
`define ETL_OFS_LEVELS 8'h10
`define ETL_OFS_EPOCH_SEC 8'h14
`define ETL_OFS_MSEC 8'h18
`define ETL_OFS_CFG_BASE 8'h20
`define ETL_OFS_CFG_LAST 8'h34

// Field positions.
`define ETL_CTRL_RESTART_BIT 0
`define ETL_CFG_ENABLE_BIT 0
`define ETL_CFG_EDGE_LSB 1
`define ETL_CFG_WAKE_SUPPRESS_BIT 3
`define ETL_CFG_STORE_LSB 4
`define ETL_CFG_DBC_LSB 16

// Reset values.
`define ETL_DBC_DEFAULT_MS 16'h0064
`define ETL_IRQ_MASK_RESET 6'h00
`define ETL_EPOCH_RESET 32'h00000000

// Timing.
`define ETL_CLK_PERIOD_NS 100
`define ETL_MS_NS 1000000
`define ETL_MS_CYCLES (`ETL_MS_NS / `ETL_CLK_PERIOD_NS)
`define ETL_MS_PER_SEC 10'h3E8

`endif

// ---- verilog/etl_pkg.sv ----
package etl_pkg;

  localparam int ETL_NUM_TRIG = 6;

  typedef enum logic [1:0] {
    ETL_EDGE_FALLING,
    ETL_EDGE_RISING,
    ETL_EDGE_BOTH,
    ETL_EDGE_OFF
  } etl_edge_t;

  typedef enum logic [2:0] {
    ETL_STORE_NONE,
    ETL_STORE_TEXT,
    ETL_STORE_CSV,
    ETL_STORE_EPOCH,
    ETL_STORE_SERIAL_ONE,
    ETL_STORE_SERIAL_TWO,
    ETL_STORE_USB,
    ETL_STORE_RSVD
  } etl_store_t;

  typedef enum logic [1:0] {
    ETL_FMT_TEXT,
    ETL_FMT_CSV,
    ETL_FMT_EPOCH,
    ETL_FMT_RSVD
  } etl_fmt_t;

  typedef struct packed {
    logic [15:0] dbc_ms;
    logic [8:0] rsvd;
    etl_store_t store;
    logic wake_suppress;
    etl_edge_t edge_mode;
    logic enable;
  } etl_trig_cfg_t;

  typedef struct packed {
    logic [2:0] trig_num;
    logic prev_lvl;
    logic new_lvl;
    etl_store_t store;
    etl_fmt_t fmt;
    logic [31:0] epoch_sec;
    logic [9:0] msec;
  } etl_rec_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } etl_av_req_t;

  typedef struct packed {
    logic bus_wait;
    logic [31:0] rdata;
    etl_trig_cfg_t [5:0] cfg;
    logic [5:0] prev;
    logic [5:0][15:0] dbc;
    logic [5:0] flags;
    logic [5:0] irq_status;
    logic [5:0] irq_mask;
    logic irq;
    logic [15:0] pre;
    logic [31:0] epoch_sec;
    logic [9:0] msec;
    logic [5:0] pend;
    etl_rec_t [5:0] pend_rec;
    logic rec_valid;
    etl_rec_t rec;
    logic file_restart;
    logic wake_req;
  } etl_state_t;

endpackage

// ---- verilog/etl_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "etl_cfg.svh"

module etl_top
  import etl_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `ETL_MS_CYCLES
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic nrst,
  // Avalon-MM slave.
  input wire logic [7:0] av_address,
  input wire logic av_read,
  input wire logic av_write,
  input wire logic [31:0] av_writedata,
  input wire logic [3:0] av_byteenable,
  output logic [31:0] av_readdata,
  output logic av_waitrequest,
  // Trigger pins.
  input wire logic [5:0] trig_pin,
  // Record stream.
  output logic rec_valid,
  output etl_rec_t rec_data,
  input wire logic rec_ready,
  // File side.
  input wire logic file_busy,
  output logic file_restart,
  // System.
  output logic wake_req,
  output logic irq
);

  etl_state_t s_reg;
  etl_state_t s_next;
  etl_av_req_t req;
  logic acc_first;
  logic acc_done;
  logic tick;
  logic hit;
  logic found;
  logic [31:0] rd_mux;
  logic [31:0] wmask;
  logic [31:0] merged;
  logic [2:0] cfg_idx;
  etl_rec_t r;

  assign req = '{address: av_address, read: av_read, write: av_write,
                 writedata: av_writedata, byteenable: av_byteenable};

  function automatic logic is_file(etl_store_t st);
    is_file = (st == ETL_STORE_TEXT) || (st == ETL_STORE_CSV) || (st == ETL_STORE_EPOCH);
  endfunction

  always_comb begin
    s_next = s_reg;
    s_next.file_restart = 1'b0;
    s_next.wake_req = 1'b0;
    acc_first = (req.read || req.write) && s_reg.bus_wait;
    acc_done = (req.read || req.write) && !s_reg.bus_wait;
    tick = (s_reg.pre == 16'(MS_CYCLES - 1));
    hit = 1'b0;
    found = 1'b0;
    rd_mux = 32'h00000000;
    r = '0;
    cfg_idx = 3'(req.address[7:2] - 6'h08);
    for (int b = 0; b < 4; b++) begin
      wmask[b * 8 +: 8] = req.byteenable[b] ? 8'hFF : 8'h00;
    end
    merged = 32'h00000000;

    // Millisecond and epoch time base.
    if (tick) begin
      s_next.pre = 16'h0000;
      if (s_reg.msec == `ETL_MS_PER_SEC - 10'h001) begin
        s_next.msec = 10'h000;
        s_next.epoch_sec = s_reg.epoch_sec + 32'h00000001;
      end else begin
        s_next.msec = s_reg.msec + 10'h001;
      end
    end else begin
      s_next.pre = s_reg.pre + 16'h0001;
    end

    // Read data multiplexer.
    case (req.address)
      `ETL_OFS_IRQ_STATUS: rd_mux = {26'h0, s_reg.irq_status};
      `ETL_OFS_IRQ_MASK: rd_mux = {26'h0, s_reg.irq_mask};
      `ETL_OFS_FLAGS: rd_mux = {26'h0, s_reg.flags};
      `ETL_OFS_LEVELS: rd_mux = {26'h0, s_reg.prev};
      `ETL_OFS_EPOCH_SEC: rd_mux = s_reg.epoch_sec;
      `ETL_OFS_MSEC: rd_mux = {22'h0, s_reg.msec};
      default: begin
        if (req.address >= `ETL_OFS_CFG_BASE && req.address <= `ETL_OFS_CFG_LAST
            && req.address[1:0] == 2'b00) begin
          rd_mux = s_reg.cfg[cfg_idx];
        end
      end
    endcase

    // Bus handshake: one wait cycle, then the answer for one cycle.
    if (acc_first) begin
      s_next.bus_wait = 1'b0;
      s_next.rdata = req.read ? rd_mux : 32'h00000000;
    end
    if (acc_done) begin
      s_next.bus_wait = 1'b1;
    end

    // Reads clear only the bits that were returned, so a set in the same cycle survives.
    if (acc_done && req.read) begin
      if (req.address == `ETL_OFS_FLAGS) begin
        s_next.flags = s_reg.flags & ~s_reg.rdata[5:0];
      end
      if (req.address == `ETL_OFS_IRQ_STATUS) begin
        s_next.irq_status = s_reg.irq_status & ~s_reg.rdata[5:0];
      end
    end

    if (acc_done && req.write) begin
      case (req.address)
        `ETL_OFS_CTRL: begin
          s_next.file_restart = req.writedata[`ETL_CTRL_RESTART_BIT] && req.byteenable[0];
        end
        `ETL_OFS_IRQ_MASK: begin
          merged = (32'(s_reg.irq_mask) & ~wmask) | (req.writedata & wmask);
          s_next.irq_mask = merged[5:0];
        end
        `ETL_OFS_EPOCH_SEC: begin
          s_next.epoch_sec = (s_reg.epoch_sec & ~wmask) | (req.writedata & wmask);
        end
        `ETL_OFS_MSEC: begin
          merged = (32'(s_reg.msec) & ~wmask) | (req.writedata & wmask);
          if (merged[9:0] < `ETL_MS_PER_SEC) begin
            s_next.msec = merged[9:0];
            s_next.pre = 16'h0000;
          end
        end
        default: begin
          if (req.address >= `ETL_OFS_CFG_BASE && req.address <= `ETL_OFS_CFG_LAST
              && req.address[1:0] == 2'b00) begin
            merged = (s_reg.cfg[cfg_idx] & ~wmask) | (req.writedata & wmask);
            merged[15:7] = 9'h000;
            s_next.cfg[cfg_idx] = merged;
          end
        end
      endcase
    end

    // Record output: one record stands until taken.
    if (s_reg.rec_valid && rec_ready) begin
      s_next.rec_valid = 1'b0;
    end
    if (!s_reg.rec_valid) begin
      for (int i = 0; i < ETL_NUM_TRIG; i++) begin
        if (!found && s_reg.pend[i] && !(is_file(s_reg.pend_rec[i].store) && file_busy)) begin
          found = 1'b1;
          s_next.rec_valid = 1'b1;
          s_next.rec = s_reg.pend_rec[i];
          s_next.pend[i] = 1'b0;
        end
      end
    end

    // Per trigger edge detect, debounce and capture.
    for (int i = 0; i < ETL_NUM_TRIG; i++) begin
      s_next.prev[i] = trig_pin[i];
      case (s_reg.cfg[i].edge_mode)
        ETL_EDGE_FALLING: hit = s_reg.prev[i] && !trig_pin[i];
        ETL_EDGE_RISING: hit = !s_reg.prev[i] && trig_pin[i];
        ETL_EDGE_BOTH: hit = s_reg.prev[i] ^ trig_pin[i];
        default: hit = 1'b0;
      endcase
      if (tick && s_reg.dbc[i] != 16'h0000) begin
        s_next.dbc[i] = s_reg.dbc[i] - 16'h0001;
      end
      if (s_reg.cfg[i].enable && hit && s_reg.dbc[i] == 16'h0000) begin
        // The hold-off counts whole ticks, so it may end up to one tick early.
        s_next.dbc[i] = s_reg.cfg[i].dbc_ms;
        s_next.flags[i] = 1'b1;
        s_next.irq_status[i] = 1'b1;
        if (!s_reg.cfg[i].wake_suppress) begin
          s_next.wake_req = 1'b1;
        end
        r.trig_num = 3'(i + 1);
        r.prev_lvl = s_reg.prev[i];
        r.new_lvl = trig_pin[i];
        r.store = s_reg.cfg[i].store;
        r.epoch_sec = s_reg.epoch_sec;
        r.msec = s_reg.msec;
        case (s_reg.cfg[i].store)
          ETL_STORE_TEXT: r.fmt = ETL_FMT_TEXT;
          ETL_STORE_EPOCH: r.fmt = ETL_FMT_EPOCH;
          default: r.fmt = ETL_FMT_CSV;
        endcase
        // A newer activation replaces an unsent record of the same trigger.
        if (s_reg.cfg[i].store != ETL_STORE_NONE && s_reg.cfg[i].store != ETL_STORE_RSVD) begin
          s_next.pend[i] = 1'b1;
          s_next.pend_rec[i] = r;
        end
      end
    end

    s_next.irq = |(s_next.irq_status & s_next.irq_mask);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '0;
      s_reg.bus_wait <= 1'b1;
      s_reg.irq_mask <= `ETL_IRQ_MASK_RESET;
      s_reg.epoch_sec <= `ETL_EPOCH_RESET;
      for (int i = 0; i < ETL_NUM_TRIG; i++) begin
        s_reg.cfg[i].dbc_ms <= `ETL_DBC_DEFAULT_MS;
        s_reg.cfg[i].edge_mode <= ETL_EDGE_FALLING;
        s_reg.cfg[i].store <= ETL_STORE_NONE;
      end
    end else begin
      s_reg <= s_next;
    end
  end

  assign av_readdata = s_reg.rdata;
  assign av_waitrequest = s_reg.bus_wait;
  assign rec_valid = s_reg.rec_valid;
  assign rec_data = s_reg.rec;
  assign file_restart = s_reg.file_restart;
  assign wake_req = s_reg.wake_req;
  assign irq = s_reg.irq;

endmodule
`default_nettype wire
